// ===== core/cpu_exec_pkg.sv
// Package: constants, codes and types used by the execute core; the register file does not import it
`default_nettype none

package cpu_exec_pkg;

   // -----------------------------------------------------------------
   // Machine cycle timing
   // -----------------------------------------------------------------
   localparam logic [2:0] PH_FIRST    = 3'h0;   // Register file read issued
   localparam logic [2:0] PH_ADDR     = 3'h1;   // Address out, latch pulse
   localparam logic [2:0] PH_WR_FIRST = 3'h2;   // First phase of write strobe
   localparam logic [2:0] PH_WR_LAST  = 3'h6;   // Last phase of write strobe
   localparam logic [2:0] PH_LAST     = 3'h7;   // Data sampled, results stored

   // -----------------------------------------------------------------
   // Machine states
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_FETCH  = 3'b000,
      ST_EXEC   = 3'b001,
      ST_DMAIN  = 3'b010,
      ST_DMAOUT = 3'b011,
      ST_INT    = 3'b100,
      ST_LOAD   = 3'b101
   } machine_state_type;

   // External state code shown on the state pins
   localparam logic [1:0] CODE_FETCH = 2'h0;
   localparam logic [1:0] CODE_EXEC  = 2'h1;
   localparam logic [1:0] CODE_DMA   = 2'h2;
   localparam logic [1:0] CODE_INT   = 2'h3;

   // -----------------------------------------------------------------
   // Opcode groups and fixed selectors
   // -----------------------------------------------------------------
   localparam logic [3:0] OPC_SET_DP  = 4'hE;   // Set data pointer group
   localparam logic [3:0] OPC_GROUP_F = 4'hF;   // Memory logic and arithmetic
   localparam logic [2:0] OPN_SHIFT   = 3'h6;   // Shift within group F
   localparam logic [3:0] DMA_PTR_SEL = 4'h0;   // DMA uses register zero
   localparam logic [3:0] INT_PC_SEL  = 4'h1;   // Program counter after entry
   localparam logic [3:0] INT_DP_SEL  = 4'h2;   // Data pointer after entry

   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic       IE_RESET    = 1'b1;
   localparam logic       CTRL_RESET  = 1'b1;
   localparam logic [3:0] MASK_RESET  = 4'h0;
   localparam logic [3:0] SEL_RESET   = 4'h0;

   // -----------------------------------------------------------------
   // Register map (byte offsets)
   // -----------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_MASK   = 8'h08;
   localparam logic [7:0] OFF_CORE   = 8'h0C;

   // Status and mask bit positions
   localparam int EV_DMAIN  = 0;
   localparam int EV_DMAOUT = 1;
   localparam int EV_INT    = 2;
   localparam int EV_LOAD   = 3;

   // Synchronised pin positions
   localparam int PIN_DMAIN  = 0;
   localparam int PIN_DMAOUT = 1;
   localparam int PIN_INT    = 2;
   localparam int PIN_CLEAR  = 3;
   localparam int PIN_WAIT   = 4;

endpackage : cpu_exec_pkg

`default_nettype wire

// ===== core/cpu_reg_file.sv
// Sixteen by sixteen-bit register matrix with registered read data
`default_nettype none

module cpu_reg_file (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // Write port
   input  wire logic        writeEn,
   input  wire logic [3:0]  writeAddr,
   input  wire logic [15:0] writeData,
   // Read port
   input  wire logic [3:0]  readAddr,
   output logic      [15:0] readData
);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [15:0][15:0] mem;      // Register matrix
      logic [15:0]       rdata;    // Read data register
   } reg_file_type;

   reg_file_type r;                // Current state
   reg_file_type n;                // Next state

   // Read returns the old word on a same-cycle write; callers read a cycle later
   always_comb begin
      n = r;
      if (writeEn) begin
         n.mem[writeAddr] = writeData;
      end
      n.rdata = r.mem[readAddr];
   end

   // State register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign readData = r.rdata;

endmodule : cpu_reg_file

`default_nettype wire

// ===== core/cpu_exec_core.sv
// Execute, DMA, interrupt entry and load mode sequencing of an 8-bit CPU core
//
// Summary of operation
// - Immediate OR into accumulator, advance counter
// - Immediate AND into accumulator, advance counter
// - Immediate XOR into accumulator, advance counter
// - Immediate byte minus accumulator, borrow to carry
// - Accumulator minus immediate byte, borrow to carry
// - Indirect load and logic via data pointer
// - Indirect accumulator minus memory, borrow to carry
// - Shift right, low bit to carry
// - DMA in writes bus byte at register zero
// - DMA out reads memory at register zero
// - DMA input wins over DMA output
// - Interrupt entry saves selectors, disables, reselects
// - Clear and wait low: idle load mode
// - Load mode suppresses latch pulse, awaits DMA
//
// Added by the designer: the Wishbone interface to the registers and the address map.
`default_nettype none

module cpu_exec_core (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // System bus pins
   output logic      [15:0] memoryAddress,
   input  wire logic [7:0]  dataBusIn,
   output logic             memoryReadStrobe_b,
   output logic             memoryWriteStrobe_b,
   output logic             addressLatchPulse,
   output logic             secondTimingPulse,
   output logic      [1:0]  stateCode,
   // Control pins
   input  wire logic        dmaInRequest,
   input  wire logic        dmaOutRequest,
   input  wire logic        interruptRequest,
   input  wire logic        clear_b,
   input  wire logic        wait_b,
   output logic             interruptEnable,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Interrupt to software
   output logic             irq
);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef struct packed {
      cpu_exec_pkg::machine_state_type state;   // Machine state
      logic [2:0]  phase;                        // Phase within machine cycle
      logic [7:0]  opcode;                       // Fetched instruction
      logic [7:0]  acc;                          // Accumulator
      logic        carry;                        // Carry flag
      logic        ie;                           // Interrupt enable
      logic [3:0]  xSel;                         // Data-pointer selector
      logic [3:0]  pSel;                         // Program-counter selector
      logic [7:0]  tReg;                         // Saved selectors
      logic [15:0] regVal;                       // Selected register value
      logic [15:0] addr;                         // Address pins
      logic        rd_b;                         // Read strobe pin
      logic        wr_b;                         // Write strobe pin
      logic        alp;                          // Address latch pulse pin
      logic        second_timing_pulse;                          // Second timing pulse pin
      logic [1:0]  code;                         // State code pins
      logic [4:0]  pinSync1;                     // First synchroniser stage
      logic [4:0]  pinSync2;                     // Second synchroniser stage
      logic [7:0]  dataSync1;                    // Data bus first stage
      logic [7:0]  dataSync2;                    // Data bus second stage
      logic        ack;                          // Bus acknowledge
      logic [31:0] datO;                         // Bus read data
      logic        ctrl;                         // Interrupt pin allowed
      logic [3:0]  status;                       // Sticky events
      logic [3:0]  mask;                         // Event mask
      logic        irq;                          // Interrupt output
   } core_state_type;

   core_state_type r;                            // Current state
   core_state_type n;                            // Next state

   // -----------------------------------------------------------------
   // Register file port signals
   // -----------------------------------------------------------------
   logic        rfWe;                            // Write enable
   logic [3:0]  rfWaddr;                         // Write index
   logic [15:0] rfWdata;                         // Write word
   logic [3:0]  rfRaddr;                         // Read index
   logic [15:0] rfRdata;                         // Registered read word

   // Combinational helpers
   logic [3:0]  sel;                             // Register used this cycle
   logic [7:0]  mdata;                           // Sampled data byte
   logic [8:0]  sum;                             // Adder result with carry
   logic [3:0]  evt;                             // Event pulses
   logic [3:0]  clr;                             // Status bits reported
   logic        readCycle;                       // Memory read this cycle
   logic        dmaIn;                           // Synchronised DMA in request
   logic        dmaOut;                          // Synchronised DMA out request
   logic        intPend;                         // Interrupt may be taken
   logic        loadMode;                        // Clear and wait both low
   cpu_exec_pkg::machine_state_type after;       // State after cycle end

   // -----------------------------------------------------------------
   // Register matrix
   // -----------------------------------------------------------------
   cpu_reg_file u_reg_file (
      .clk       (clk),
      .rst_b     (rst_b),
      .writeEn   (rfWe),
      .writeAddr (rfWaddr),
      .writeData (rfWdata),
      .readAddr  (rfRaddr),
      .readData  (rfRdata)
   );

   // -----------------------------------------------------------------
   // Next-state logic
   // -----------------------------------------------------------------
   // Each machine cycle lasts eight clocks so that synchronised data
   // from slow memories settles before it is sampled in the last phase.
   always_comb begin
      n         = r;
      rfWe      = 1'b0;
      rfWaddr   = cpu_exec_pkg::SEL_RESET;
      rfWdata   = 16'h0000;
      sel       = r.pSel;
      mdata     = r.dataSync2;
      sum       = 9'h000;
      evt       = 4'h0;
      clr       = 4'h0;
      readCycle = 1'b0;
      after     = cpu_exec_pkg::ST_FETCH;

      // Two-stage synchronisers; only stage two is read by logic
      n.pinSync1  = {wait_b, clear_b, interruptRequest, dmaOutRequest, dmaInRequest};
      n.pinSync2  = r.pinSync1;
      n.dataSync1 = dataBusIn;
      n.dataSync2 = r.dataSync1;
      dmaIn    = r.pinSync2[cpu_exec_pkg::PIN_DMAIN];
      dmaOut   = r.pinSync2[cpu_exec_pkg::PIN_DMAOUT];
      intPend  = r.pinSync2[cpu_exec_pkg::PIN_INT] & r.ie & r.ctrl;
      loadMode = ~r.pinSync2[cpu_exec_pkg::PIN_CLEAR] & ~r.pinSync2[cpu_exec_pkg::PIN_WAIT];

      // Register and strobe selection for the current state
      case (r.state)
         cpu_exec_pkg::ST_FETCH: begin
            sel       = r.pSel;
            readCycle = 1'b1;
         end
         cpu_exec_pkg::ST_EXEC: begin
            if (r.opcode[7:4] == cpu_exec_pkg::OPC_GROUP_F) begin
               // Indirect forms address through the data pointer
               sel       = r.opcode[3] ? r.pSel : r.xSel;
               readCycle = (r.opcode[2:0] != cpu_exec_pkg::OPN_SHIFT);
            end else if (r.opcode[7:4] == cpu_exec_pkg::OPC_SET_DP) begin
               sel = r.opcode[3:0];
            end else begin
               sel = r.pSel;
            end
         end
         cpu_exec_pkg::ST_DMAIN: begin
            sel = cpu_exec_pkg::DMA_PTR_SEL;
         end
         cpu_exec_pkg::ST_DMAOUT: begin
            sel       = cpu_exec_pkg::DMA_PTR_SEL;
            readCycle = 1'b1;
         end
         cpu_exec_pkg::ST_LOAD: begin
            sel       = cpu_exec_pkg::DMA_PTR_SEL;
            readCycle = 1'b1;
         end
         default: begin
            sel = r.pSel;
         end
      endcase
      rfRaddr = sel;

      // Latch the selected register and drive the address pins
      if (r.phase == cpu_exec_pkg::PH_ADDR) begin
         n.regVal = rfRdata;
         if (r.state == cpu_exec_pkg::ST_LOAD) begin
            n.addr = 16'(rfRdata - 16'h0001);
         end else begin
            n.addr = rfRdata;
         end
      end

      // Choice of the next machine cycle at a cycle boundary
      if (dmaIn) begin
         after = cpu_exec_pkg::ST_DMAIN;
      end else if (dmaOut) begin
         after = cpu_exec_pkg::ST_DMAOUT;
      end else if (intPend && r.state != cpu_exec_pkg::ST_INT) begin
         after = cpu_exec_pkg::ST_INT;
      end else if (loadMode) begin
         after = cpu_exec_pkg::ST_LOAD;
      end else begin
         after = cpu_exec_pkg::ST_FETCH;
      end

      // End of machine cycle: store results and move on
      n.phase = 3'(r.phase + 3'h1);
      if (r.phase == cpu_exec_pkg::PH_LAST) begin
         n.state = after;
         case (r.state)
            cpu_exec_pkg::ST_FETCH: begin
               n.opcode = mdata;
               rfWe     = 1'b1;
               rfWaddr  = r.pSel;
               rfWdata  = 16'(r.regVal + 16'h0001);
               // Execution always follows fetch; DMA waits for its end
               n.state  = cpu_exec_pkg::ST_EXEC;
            end
            cpu_exec_pkg::ST_EXEC: begin
               if (r.opcode[7:4] == cpu_exec_pkg::OPC_SET_DP) begin
                  n.xSel = r.opcode[3:0];
               end else if (r.opcode[7:4] == cpu_exec_pkg::OPC_GROUP_F) begin
                  case (r.opcode[2:0])
                     3'h0: begin
                        n.acc = mdata;
                     end
                     3'h1: begin
                        n.acc = mdata | r.acc;
                     end
                     3'h2: begin
                        n.acc = mdata & r.acc;
                     end
                     3'h3: begin
                        n.acc = mdata ^ r.acc;
                     end
                     3'h4: begin
                        sum     = {1'b0, mdata} + {1'b0, r.acc};
                        n.acc   = sum[7:0];
                        n.carry = sum[8];
                     end
                     3'h5: begin
                        // Carry set means no borrow
                        sum     = {1'b0, mdata} + {1'b0, ~r.acc} + 9'h001;
                        n.acc   = sum[7:0];
                        n.carry = sum[8];
                     end
                     3'h6: begin
                        if (r.opcode[3]) begin
                           n.carry = r.acc[7];
                           n.acc   = {r.acc[6:0], 1'b0};
                        end else begin
                           n.carry = r.acc[0];
                           n.acc   = {1'b0, r.acc[7:1]};
                        end
                     end
                     default: begin
                        sum     = {1'b0, r.acc} + {1'b0, ~mdata} + 9'h001;
                        n.acc   = sum[7:0];
                        n.carry = sum[8];
                     end
                  endcase
                  // Immediate forms step the program counter
                  if (r.opcode[3] && r.opcode[2:0] != cpu_exec_pkg::OPN_SHIFT) begin
                     rfWe    = 1'b1;
                     rfWaddr = r.pSel;
                     rfWdata = 16'(r.regVal + 16'h0001);
                  end
               end
            end
            cpu_exec_pkg::ST_DMAIN, cpu_exec_pkg::ST_DMAOUT: begin
               rfWe    = 1'b1;
               rfWaddr = cpu_exec_pkg::DMA_PTR_SEL;
               rfWdata = 16'(r.regVal + 16'h0001);
               evt[cpu_exec_pkg::EV_DMAIN]  = (r.state == cpu_exec_pkg::ST_DMAIN);
               evt[cpu_exec_pkg::EV_DMAOUT] = (r.state == cpu_exec_pkg::ST_DMAOUT);
            end
            cpu_exec_pkg::ST_INT: begin
               n.tReg = {r.xSel, r.pSel};
               n.ie   = 1'b0;
               n.pSel = cpu_exec_pkg::INT_PC_SEL;
               n.xSel = cpu_exec_pkg::INT_DP_SEL;
               evt[cpu_exec_pkg::EV_INT] = 1'b1;
            end
            default: begin
               // Load mode idles until a DMA request arrives
            end
         endcase
         evt[cpu_exec_pkg::EV_LOAD] = (n.state == cpu_exec_pkg::ST_LOAD) &&
                                      (r.state != cpu_exec_pkg::ST_LOAD);
      end

      // Pin outputs for the coming clock, registered straight to pins
      n.rd_b = ~(readCycle && n.phase != cpu_exec_pkg::PH_FIRST);
      n.wr_b = ~(r.state == cpu_exec_pkg::ST_DMAIN &&
                 n.phase >= cpu_exec_pkg::PH_WR_FIRST &&
                 n.phase <= cpu_exec_pkg::PH_WR_LAST);
      n.alp  = (n.phase == cpu_exec_pkg::PH_ADDR) &&
               (r.state != cpu_exec_pkg::ST_LOAD);
      n.second_timing_pulse  = (n.phase == cpu_exec_pkg::PH_LAST) &&
               (n.state != cpu_exec_pkg::ST_LOAD);
      case (n.state)
         cpu_exec_pkg::ST_FETCH: begin
            n.code = cpu_exec_pkg::CODE_FETCH;
         end
         cpu_exec_pkg::ST_DMAIN, cpu_exec_pkg::ST_DMAOUT: begin
            n.code = cpu_exec_pkg::CODE_DMA;
         end
         cpu_exec_pkg::ST_INT: begin
            n.code = cpu_exec_pkg::CODE_INT;
         end
         default: begin
            n.code = cpu_exec_pkg::CODE_EXEC;
         end
      endcase

      // Wishbone slave: ack one cycle after request, dropped the next
      n.ack = wb_cyc_i & wb_stb_i & ~r.ack;
      if (wb_cyc_i && wb_stb_i && !r.ack) begin
         case (wb_adr_i)
            cpu_exec_pkg::OFF_CTRL: begin
               n.datO = {31'h00000000, r.ctrl};
            end
            cpu_exec_pkg::OFF_STATUS: begin
               n.datO = {28'h0000000, r.status};
            end
            cpu_exec_pkg::OFF_MASK: begin
               n.datO = {28'h0000000, r.mask};
            end
            cpu_exec_pkg::OFF_CORE: begin
               n.datO = {4'h0, r.xSel, r.pSel, 2'h0, r.code, 6'h00,
                         r.ie, r.carry, r.acc};
            end
            default: begin
               n.datO = 32'h00000000;
            end
         endcase
      end
      // Writes and read-clear land on the edge where ack is sampled
      if (wb_cyc_i && wb_stb_i && r.ack) begin
         if (wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == cpu_exec_pkg::OFF_CTRL) begin
               n.ctrl = wb_dat_i[0];
            end
            if (wb_adr_i == cpu_exec_pkg::OFF_MASK) begin
               n.mask = wb_dat_i[3:0];
            end
         end
         if (!wb_we_i && wb_adr_i == cpu_exec_pkg::OFF_STATUS) begin
            // Only clear what was reported, so late events survive
            clr = r.datO[3:0];
         end
      end
      n.status = (r.status & ~clr) | evt;
      n.irq    = |(n.status & n.mask);
   end

   // -----------------------------------------------------------------
   // State register
   // -----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         r       <= '0;
         r.state <= cpu_exec_pkg::ST_FETCH;
         r.ie    <= cpu_exec_pkg::IE_RESET;
         r.ctrl  <= cpu_exec_pkg::CTRL_RESET;
         r.mask  <= cpu_exec_pkg::MASK_RESET;
         r.rd_b  <= 1'b1;
         r.wr_b  <= 1'b1;
      end else begin
         r <= n;
      end
   end

   // -----------------------------------------------------------------
   // Outputs, each from its flip-flop
   // -----------------------------------------------------------------
   assign memoryAddress       = r.addr;
   assign memoryReadStrobe_b  = r.rd_b;
   assign memoryWriteStrobe_b = r.wr_b;
   assign addressLatchPulse   = r.alp;
   assign secondTimingPulse   = r.second_timing_pulse;
   assign stateCode           = r.code;
   assign interruptEnable     = r.ie;
   assign wb_dat_o            = r.datO;
   assign wb_ack_o            = r.ack;
   assign irq                 = r.irq;

endmodule : cpu_exec_core

`default_nettype wire

// ===== dv/exec_core_sva.sv
// Checker for bus timing and state pins of the execute core
`default_nettype none
module exec_core_sva (
   // Clock, reset and watched pins
   input wire logic        clk, rst_b, memoryReadStrobe_b, memoryWriteStrobe_b,
   input wire logic        addressLatchPulse, secondTimingPulse, interruptEnable,
   input wire logic        wb_cyc_i, wb_stb_i, wb_ack_o,
   input wire logic [15:0] memoryAddress,
   input wire logic [1:0]  stateCode
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // ---------------
   // Properties
   // ---------------
   a_ack_one_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
   a_write_dma_only: assert property (!memoryWriteStrobe_b |->
      stateCode == 2'h2 && memoryReadStrobe_b) else $error("stray write");
   a_int_floats: assert property (stateCode == 2'h3 |->
      memoryReadStrobe_b && memoryWriteStrobe_b) else $error("strobe in entry");
   a_int_clears_ie: assert property ($rose(stateCode == 2'h3) |->
      ##[0:8] !interruptEnable) else $error("enable kept");
   a_pulse_pair: assert property (addressLatchPulse |-> ##6 secondTimingPulse)
      else $error("no second pulse");
   a_addr_stands: assert property (addressLatchPulse ##1 1'b1 |=> $stable(memoryAddress)[*6])
      else $error("address moved");
   a_read_spans: assert property ($fell(memoryReadStrobe_b) |->
      !memoryReadStrobe_b[*7]) else $error("read short");
   // Main scenarios reached
   c_dma: cover property (stateCode == 2'h2);
   c_int: cover property (stateCode == 2'h3);
   c_write: cover property (!memoryWriteStrobe_b);
endmodule : exec_core_sva
`default_nettype wire

// ===== dv/bus_memory_model.sv
// Memory with boot image and I/O byte source on the far side of the bus
`default_nettype none
module bus_memory_model (
   // Clock and system bus
   input  wire logic        clk, memoryReadStrobe_b, memoryWriteStrobe_b,
   input  wire logic [15:0] memoryAddress,
   input  wire logic [7:0]  ioByte,
   output logic      [7:0]  dataBusIn
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] PROG [17] = '{8'hF8, 8'hC3, 8'hF9, 8'h0C, 8'hFA, 8'h3C, 8'hFB,
      8'h0F, 8'hF6, 8'hFE, 8'hFF, 8'h10, 8'hFD, 8'hF3, 8'hE5, 8'hF2, 8'hF7};
   logic [7:0] mem [256];  // Address wraps at 256
   initial begin
      foreach (mem[i]) mem[i] = (i < 17) ? PROG[i] : 8'h00;
      dataBusIn = 8'h00;
   end
   // Memory answers a read, I/O device feeds a DMA write
   always @(posedge clk) begin
      if (!memoryReadStrobe_b) begin
         dataBusIn <= mem[memoryAddress[7:0]];
      end else if (!memoryWriteStrobe_b) begin
         dataBusIn <= ioByte;
         mem[memoryAddress[7:0]] <= ioByte;
      end else begin
         dataBusIn <= ~dataBusIn;  // Released bus must not look held
      end
   end
endmodule : bus_memory_model
`default_nettype wire

// ===== dv/cpu_execute_dma_interrupt_states_tb_top.sv
// Testbench top: program, DMA, interrupt entry and load mode scenarios
`default_nettype none
`define CHK(a, e) begin checkCount++; if ((a) !== (e)) begin nMismatch++; \
   $display("Error %0t: got %h expected %h", $time, a, e); end end
module cpu_execute_dma_interrupt_states_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst_b = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic dmaInRequest = 1'b0, dmaOutRequest = 1'b0, interruptRequest = 1'b0;
   logic clear_b = 1'b1, wait_b = 1'b1, sawA, sawB;
   logic [7:0] wb_adr_i = 8'h00, ioByte = 8'hA5, dataBusIn;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdData;
   logic [15:0] memoryAddress, zeroRegAddr;
   logic memoryReadStrobe_b, memoryWriteStrobe_b, addressLatchPulse, secondTimingPulse;
   logic interruptEnable, wb_ack_o, irq;
   logic [1:0] stateCode;
   int nMismatch = 0, checkCount = 0;
   always #2 clk = ~clk;  // 250 MHz
   cpu_exec_core dut_u (.clk, .rst_b, .memoryAddress, .dataBusIn, .memoryReadStrobe_b,
      .memoryWriteStrobe_b, .addressLatchPulse, .secondTimingPulse, .stateCode, .dmaInRequest,
      .dmaOutRequest, .interruptRequest, .clear_b, .wait_b, .interruptEnable, .wb_cyc_i,
      .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq);
   bus_memory_model mem_u (.clk, .memoryReadStrobe_b, .memoryWriteStrobe_b, .memoryAddress,
      .ioByte, .dataBusIn);
   // Single Wishbone access; request held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
      do begin @(posedge clk); n++; end while (wb_ack_o !== 1'b1 && n < 20);
      `CHK(wb_ack_o, 1'b1)
      rdData = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
      @(posedge clk);
   endtask : wb
   // Watch strobes and latch pulse over seven clocks of one machine cycle
   task automatic watch();
      {sawA, sawB} = 2'b00;
      repeat (7) begin
         @(posedge clk);
         sawA = sawA | ~memoryWriteStrobe_b | addressLatchPulse;
         sawB = sawB | ~memoryReadStrobe_b;
      end
   endtask : watch
   task automatic t_dma();
      {dmaInRequest, dmaOutRequest} <= 2'b11;
      for (int i = 0; i < 40 && stateCode !== 2'h2; i++) @(posedge clk);
      watch();
      `CHK({sawA, sawB}, 2'b10)
      `CHK(mem_u.mem[memoryAddress[7:0]], ioByte)
      dmaInRequest <= 1'b0;
      repeat (40) @(posedge clk);
      dmaOutRequest <= 1'b0;
      repeat (20) @(posedge clk);
      wb(1'b0, 8'h04, 32'h0);
      `CHK(rdData, 32'h3)
      $display("dma test done");
   endtask : t_dma
   task automatic t_irq();
      wb(1'b1, 8'h08, 32'h4);
      interruptRequest <= 1'b1;
      for (int i = 0; i < 60 && irq !== 1'b1; i++) @(posedge clk);
      zeroRegAddr = memoryAddress;  // Entry cycle still shows register zero
      interruptRequest <= 1'b0;
      repeat (8) @(posedge clk);
      wb(1'b0, 8'h0C, 32'h0);
      `CHK(rdData & 32'h0FF0_0200, 32'h0210_0000)
      wb(1'b0, 8'h04, 32'h0);
      `CHK(rdData, 32'h4)
      wb(1'b0, 8'h10, 32'h0);
      `CHK({irq, rdData}, 33'h0)
      $display("interrupt test done");
   endtask : t_irq
   task automatic results();
      $display("Comparisons %0d mismatches %0d", checkCount, nMismatch);
      if (nMismatch == 0 && checkCount > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : results
   initial begin
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      repeat (400) @(posedge clk);
      wb(1'b0, 8'h0C, 32'h0);  // Program leaves acc 08, carry 0, X 5
      `CHK(rdData & 32'h0F00_03FF, 32'h0500_0208)
      $display("program test done");
      t_dma();
      t_irq();
      {clear_b, wait_b} <= 2'b00;
      repeat (40) @(posedge clk);
      watch();
      `CHK({sawA, sawB}, 2'b01)
      `CHK(memoryAddress, 16'(zeroRegAddr - 16'h0001))
      wb(1'b0, 8'h04, 32'h0);
      `CHK(rdData, 32'h8)
      $display("load test done");
      results();
   end
   initial begin
      repeat (3000) @(posedge clk);
      nMismatch++;
      results();
   end
endmodule : cpu_execute_dma_interrupt_states_tb_top
bind cpu_exec_core exec_core_sva chk_u (.clk, .rst_b, .memoryReadStrobe_b, .memoryWriteStrobe_b,
   .addressLatchPulse, .secondTimingPulse, .interruptEnable, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
   .memoryAddress, .stateCode);
`default_nettype wire
